// ### hw/external_memory_interface_defs.svh
// Constants for the external memory pin control block
`ifndef EXTERNAL_MEMORY_INTERFACE_DEFS_SVH
`define EXTERNAL_MEMORY_INTERFACE_DEFS_SVH
`define EXTERNAL_MEMORY_INTERFACE_CFG_OFS 8'h00
`define EXTERNAL_MEMORY_INTERFACE_TIM_OFS 8'h04
`define EXTERNAL_MEMORY_INTERFACE_PAGE_OFS 8'h08
`define EXTERNAL_MEMORY_INTERFACE_LATCH_OFS 8'h0C
`define EXTERNAL_MEMORY_INTERFACE_MODE_OFS 8'h10
`define EXTERNAL_MEMORY_INTERFACE_STAT_OFS 8'h14
`define EXTERNAL_MEMORY_INTERFACE_CFG_MODE 1:0
`define EXTERNAL_MEMORY_INTERFACE_CFG_NONMUX 2
`define EXTERNAL_MEMORY_INTERFACE_CFG_PORTEN 3
`define EXTERNAL_MEMORY_INTERFACE_CFG_W 4
`define EXTERNAL_MEMORY_INTERFACE_CFG_RST 4'h0
`define EXTERNAL_MEMORY_INTERFACE_TIM_SETUP 3:0
`define EXTERNAL_MEMORY_INTERFACE_TIM_STRB 7:4
`define EXTERNAL_MEMORY_INTERFACE_TIM_HOLD 11:8
`define EXTERNAL_MEMORY_INTERFACE_TIM_W 12
`define EXTERNAL_MEMORY_INTERFACE_TIM_RST 12'h111
`define EXTERNAL_MEMORY_INTERFACE_LATCH_RST 32'hFFFF_FFFF
`define EXTERNAL_MEMORY_INTERFACE_PP_RST 32'h0000_0000
`define EXTERNAL_MEMORY_INTERFACE_PAGE_RST 8'h00
`define EXTERNAL_MEMORY_INTERFACE_MEM_ONCHIP 2'h0
`define EXTERNAL_MEMORY_INTERFACE_MEM_SPLIT_NOBANK 2'h1
`define EXTERNAL_MEMORY_INTERFACE_MEM_SPLIT_BANK 2'h2
`define EXTERNAL_MEMORY_INTERFACE_MEM_OFFCHIP 2'h3
`define EXTERNAL_MEMORY_INTERFACE_ONCHIP_TOP 16'h2000
`define EXTERNAL_MEMORY_INTERFACE_P1 7:0
`define EXTERNAL_MEMORY_INTERFACE_P2 15:8
`define EXTERNAL_MEMORY_INTERFACE_P3 23:16
`define EXTERNAL_MEMORY_INTERFACE_P4 31:24
`define EXTERNAL_MEMORY_INTERFACE_ALE_BIT 5
`define EXTERNAL_MEMORY_INTERFACE_RD_BIT 6
`define EXTERNAL_MEMORY_INTERFACE_WR_BIT 7
`define EXTERNAL_MEMORY_INTERFACE_NPINS 32
`endif

// ### hw/external_memory_interface_pkg.sv
// Types shared by the external memory pin control block
`include "external_memory_interface_defs.svh"
package external_memory_interface_pkg;
  typedef enum logic [2:0] {S_IDLE, S_ALE, S_SETUP, S_STROBE, S_HOLD} state_t;
  typedef struct packed {
    logic [`EXTERNAL_MEMORY_INTERFACE_NPINS-1:0] val;
    logic [`EXTERNAL_MEMORY_INTERFACE_NPINS-1:0] en;
  } pin_bus_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_t;
  typedef struct packed {
    logic done;
    logic onchip;
    logic [7:0] rdata;
  } mem_resp_t;
  typedef struct packed {
    state_t st;
    logic [3:0] cnt;
    logic [`EXTERNAL_MEMORY_INTERFACE_CFG_W-1:0] cfg;
    logic [`EXTERNAL_MEMORY_INTERFACE_TIM_W-1:0] tim;
    logic [7:0] page;
    logic [`EXTERNAL_MEMORY_INTERFACE_NPINS-1:0] latch;
    logic [`EXTERNAL_MEMORY_INTERFACE_NPINS-1:0] pp;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    mem_resp_t resp;
    logic [31:0] prdata;
  } ctrl_state_t;
endpackage : external_memory_interface_pkg

// ### hw/external_memory_interface_pin_mux.sv
// Per-pin owner selection and output drive for the interface ports
`timescale 1ns/1ps
`include "external_memory_interface_defs.svh"
module external_memory_interface_pin_mux
  import external_memory_interface_pkg::*;
(
  input wire logic claim,
  input wire logic [`EXTERNAL_MEMORY_INTERFACE_NPINS-1:0] own,
  input external_memory_interface_pkg::pin_bus_t emi,
  input external_memory_interface_pkg::pin_bus_t xbar,
  input wire logic [`EXTERNAL_MEMORY_INTERFACE_NPINS-1:0] xbar_sel,
  input wire logic [`EXTERNAL_MEMORY_INTERFACE_NPINS-1:0] latch,
  input wire logic [`EXTERNAL_MEMORY_INTERFACE_NPINS-1:0] push_pull,
  output external_memory_interface_pkg::pin_bus_t pins
);
  genvar i;
  generate
    for (i = 0; i < `EXTERNAL_MEMORY_INTERFACE_NPINS; i++)
    begin : g_pin
      logic v;
      logic e;
      always_comb
      begin
        if (claim && own[i])
        begin
          v = emi.val[i];
          e = emi.en[i];
        end
        else if (xbar_sel[i])
        begin
          v = xbar.val[i];
          e = xbar.en[i];
        end
        else
        begin
          v = latch[i];
          e = 1'b1;
        end
      end
      // Open-drain cells only pull low; the drive mode is never touched by the interface
      assign pins.val[i] = v;
      assign pins.en[i] = e && (push_pull[i] || !v);
    end
  endgenerate
endmodule : external_memory_interface_pin_mux

// ### hw/ext_mem_pin_ctrl.sv
// External memory interface pin control with APB register access
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "external_memory_interface_defs.svh"
module ext_mem_pin_ctrl
  import external_memory_interface_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input external_memory_interface_pkg::mem_req_t REQ,
  output logic REQ_READY,
  output external_memory_interface_pkg::mem_resp_t RESP,
  input external_memory_interface_pkg::pin_bus_t XBAR,
  input wire logic [`EXTERNAL_MEMORY_INTERFACE_NPINS-1:0] XBAR_SEL,
  input wire logic [`EXTERNAL_MEMORY_INTERFACE_NPINS-1:0] PIN_IN,
  output logic [`EXTERNAL_MEMORY_INTERFACE_NPINS-1:0] PIN_OUT,
  output logic [`EXTERNAL_MEMORY_INTERFACE_NPINS-1:0] PIN_OE
);
  import external_memory_interface_pkg::*;

  ctrl_state_t s_q;
  ctrl_state_t s_d;
  pin_bus_t emi;
  pin_bus_t pins;
  logic [`EXTERNAL_MEMORY_INTERFACE_NPINS-1:0] own;
  logic claim;
  logic nonmux;
  logic strobe;
  logic [7:0] addr_hi;
  logic apb_wr;
  logic [3:0] phase_len;

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == `EXTERNAL_MEMORY_INTERFACE_CFG_OFS) || (a == `EXTERNAL_MEMORY_INTERFACE_TIM_OFS) || (a == `EXTERNAL_MEMORY_INTERFACE_PAGE_OFS) ||
              (a == `EXTERNAL_MEMORY_INTERFACE_LATCH_OFS) || (a == `EXTERNAL_MEMORY_INTERFACE_MODE_OFS) || (a == `EXTERNAL_MEMORY_INTERFACE_STAT_OFS);
  endfunction : reg_hit

  function automatic logic is_offchip(input logic [`EXTERNAL_MEMORY_INTERFACE_CFG_W-1:0] cfg, input logic [15:0] a);
    logic split;
    split = (cfg[`EXTERNAL_MEMORY_INTERFACE_CFG_MODE] == `EXTERNAL_MEMORY_INTERFACE_MEM_SPLIT_NOBANK) || (cfg[`EXTERNAL_MEMORY_INTERFACE_CFG_MODE] == `EXTERNAL_MEMORY_INTERFACE_MEM_SPLIT_BANK);
    is_offchip = cfg[`EXTERNAL_MEMORY_INTERFACE_CFG_PORTEN] &&
                 ((cfg[`EXTERNAL_MEMORY_INTERFACE_CFG_MODE] == `EXTERNAL_MEMORY_INTERFACE_MEM_OFFCHIP) || (split && a >= `EXTERNAL_MEMORY_INTERFACE_ONCHIP_TOP));
  endfunction : is_offchip

  assign claim = (s_q.st != S_IDLE);
  assign nonmux = s_q.cfg[`EXTERNAL_MEMORY_INTERFACE_CFG_NONMUX];
  assign strobe = (s_q.st == S_STROBE);
  // Without bank select the upper address byte comes from the page register
  assign addr_hi = (s_q.cfg[`EXTERNAL_MEMORY_INTERFACE_CFG_MODE] == `EXTERNAL_MEMORY_INTERFACE_MEM_SPLIT_NOBANK) ? s_q.page : s_q.addr[15:8];
  assign apb_wr = PSEL && PENABLE && PWRITE && reg_hit(PADDR);

  always_comb
  begin
    own = '0;
    emi.val = '0;
    emi.en = '0;
    own[`EXTERNAL_MEMORY_INTERFACE_RD_BIT] = 1'b1;
    own[`EXTERNAL_MEMORY_INTERFACE_WR_BIT] = 1'b1;
    own[`EXTERNAL_MEMORY_INTERFACE_ALE_BIT] = !nonmux;
    own[`EXTERNAL_MEMORY_INTERFACE_P2] = 8'hFF;
    own[`EXTERNAL_MEMORY_INTERFACE_P3] = 8'hFF;
    own[`EXTERNAL_MEMORY_INTERFACE_P4] = nonmux ? 8'hFF : 8'h00;
    emi.val[`EXTERNAL_MEMORY_INTERFACE_RD_BIT] = !(strobe && !s_q.wr);
    emi.val[`EXTERNAL_MEMORY_INTERFACE_WR_BIT] = !(strobe && s_q.wr);
    emi.val[`EXTERNAL_MEMORY_INTERFACE_ALE_BIT] = (s_q.st == S_ALE);
    emi.en[`EXTERNAL_MEMORY_INTERFACE_P1] = 8'hFF;
    emi.val[`EXTERNAL_MEMORY_INTERFACE_P2] = addr_hi;
    emi.en[`EXTERNAL_MEMORY_INTERFACE_P2] = 8'hFF;
    if (nonmux)
    begin
      emi.val[`EXTERNAL_MEMORY_INTERFACE_P3] = s_q.addr[7:0];
      emi.en[`EXTERNAL_MEMORY_INTERFACE_P3] = 8'hFF;
      emi.val[`EXTERNAL_MEMORY_INTERFACE_P4] = s_q.wdata;
      emi.en[`EXTERNAL_MEMORY_INTERFACE_P4] = s_q.wr ? 8'hFF : 8'h00;
    end
    else
    begin
      emi.val[`EXTERNAL_MEMORY_INTERFACE_P3] = (s_q.st == S_ALE) ? s_q.addr[7:0] : s_q.wdata;
      emi.en[`EXTERNAL_MEMORY_INTERFACE_P3] = ((s_q.st == S_ALE) || s_q.wr) ? 8'hFF : 8'h00;
    end
  end

  always_comb
  begin
    case (s_q.st)
      S_SETUP: phase_len = s_q.tim[`EXTERNAL_MEMORY_INTERFACE_TIM_SETUP];
      S_STROBE: phase_len = s_q.tim[`EXTERNAL_MEMORY_INTERFACE_TIM_STRB];
      S_HOLD: phase_len = s_q.tim[`EXTERNAL_MEMORY_INTERFACE_TIM_HOLD];
      default: phase_len = 4'h1;
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    s_d.resp.done = 1'b0;
    s_d.resp.onchip = 1'b0;
    if (PSEL && !PENABLE)
    begin
      case (PADDR)
        `EXTERNAL_MEMORY_INTERFACE_CFG_OFS: s_d.prdata = {28'h000_0000, s_q.cfg};
        `EXTERNAL_MEMORY_INTERFACE_TIM_OFS: s_d.prdata = {20'h0_0000, s_q.tim};
        `EXTERNAL_MEMORY_INTERFACE_PAGE_OFS: s_d.prdata = {24'h00_0000, s_q.page};
        `EXTERNAL_MEMORY_INTERFACE_LATCH_OFS: s_d.prdata = s_q.latch;
        `EXTERNAL_MEMORY_INTERFACE_MODE_OFS: s_d.prdata = s_q.pp;
        `EXTERNAL_MEMORY_INTERFACE_STAT_OFS: s_d.prdata = {23'h00_0000, s_q.resp.rdata, claim};
        default: s_d.prdata = 32'h0000_0000;
      endcase
    end
    if (apb_wr)
    begin
      case (PADDR)
        `EXTERNAL_MEMORY_INTERFACE_CFG_OFS: s_d.cfg = PWDATA[`EXTERNAL_MEMORY_INTERFACE_CFG_W-1:0];
        `EXTERNAL_MEMORY_INTERFACE_TIM_OFS: s_d.tim = PWDATA[`EXTERNAL_MEMORY_INTERFACE_TIM_W-1:0];
        `EXTERNAL_MEMORY_INTERFACE_PAGE_OFS: s_d.page = PWDATA[7:0];
        `EXTERNAL_MEMORY_INTERFACE_LATCH_OFS: s_d.latch = PWDATA;
        `EXTERNAL_MEMORY_INTERFACE_MODE_OFS: s_d.pp = PWDATA;
        default: s_d.cnt = s_q.cnt;
      endcase
    end
    // A phase field of zero still lasts one cycle
    s_d.cnt = s_q.cnt + 4'h1;
    case (s_q.st)
      S_IDLE:
      begin
        s_d.cnt = 4'h0;
        if (REQ.valid)
        begin
          s_d.addr = REQ.addr;
          s_d.wdata = REQ.wdata;
          s_d.wr = REQ.write;
          if (is_offchip(s_q.cfg, REQ.addr))
            s_d.st = nonmux ? S_SETUP : S_ALE;
          else
          begin
            s_d.resp.done = 1'b1;
            s_d.resp.onchip = 1'b1;
          end
        end
      end
      S_ALE:
      begin
        s_d.cnt = 4'h0;
        s_d.st = S_SETUP;
      end
      S_SETUP, S_STROBE, S_HOLD:
      begin
        if (s_q.cnt + 4'h1 >= phase_len)
        begin
          s_d.cnt = 4'h0;
          if (s_q.st == S_SETUP)
            s_d.st = S_STROBE;
          else if (s_q.st == S_STROBE)
          begin
            s_d.st = S_HOLD;
            if (!s_q.wr)
              s_d.resp.rdata = nonmux ? PIN_IN[`EXTERNAL_MEMORY_INTERFACE_P4] : PIN_IN[`EXTERNAL_MEMORY_INTERFACE_P3];
          end
          else
          begin
            s_d.st = S_IDLE;
            s_d.resp.done = 1'b1;
          end
        end
      end
      default: s_d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RESET)
  begin
    if (RESET)
    begin
      s_q <= '0;
      s_q.st <= S_IDLE;
      s_q.cfg <= `EXTERNAL_MEMORY_INTERFACE_CFG_RST;
      s_q.tim <= `EXTERNAL_MEMORY_INTERFACE_TIM_RST;
      s_q.page <= `EXTERNAL_MEMORY_INTERFACE_PAGE_RST;
      s_q.latch <= `EXTERNAL_MEMORY_INTERFACE_LATCH_RST;
      s_q.pp <= `EXTERNAL_MEMORY_INTERFACE_PP_RST;
    end
    else
      s_q <= s_d;
  end

  external_memory_interface_pin_mux u_pins (
    .claim(claim),
    .own(own),
    .emi(emi),
    .xbar(XBAR),
    .xbar_sel(XBAR_SEL),
    .latch(s_q.latch),
    .push_pull(s_q.pp),
    .pins(pins)
  );

  assign PIN_OUT = pins.val;
  assign PIN_OE = pins.en;
  assign PRDATA = s_q.prdata;
  assign PREADY = PSEL && PENABLE;
  assign PSLVERR = PSEL && PENABLE && !reg_hit(PADDR);
  assign REQ_READY = (s_q.st == S_IDLE);
  assign RESP = s_q.resp;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  // Open-drain address lines only drive their zeros, so the enable follows the value there
  a_pins_ports_used: assert property (strobe |-> PIN_OUT[`EXTERNAL_MEMORY_INTERFACE_P2] == addr_hi && PIN_OE[`EXTERNAL_MEMORY_INTERFACE_P2] == (s_q.pp[`EXTERNAL_MEMORY_INTERFACE_P2] | ~addr_hi))
    else $error("Upper address not on port 2 during strobe");
  a_claim_offchip: assert property ((REQ.valid && REQ_READY && !is_offchip(s_q.cfg, REQ.addr)) |=> !claim)
    else $error("Pins claimed for an on-chip access");
  a_release_latch: assert property ((!claim && XBAR_SEL[`EXTERNAL_MEMORY_INTERFACE_P2] == 8'h00) |-> PIN_OUT[`EXTERNAL_MEMORY_INTERFACE_P2] == s_q.latch[`EXTERNAL_MEMORY_INTERFACE_P2])
    else $error("Idle port 2 does not show its latch");
  a_read_undriven: assert property ((claim && !s_q.wr && s_q.st != S_ALE) |-> PIN_OE[`EXTERNAL_MEMORY_INTERFACE_P3] == 8'h00 || nonmux)
    else $error("Data lines driven during a read");
  a_drive_mode_kept: assert property ((PIN_OE & ~s_q.pp & PIN_OUT) == 32'h0000_0000)
    else $error("Open-drain pin driven high");
  a_mux_ale: assert property ((s_q.st == S_ALE) |-> PIN_OUT[`EXTERNAL_MEMORY_INTERFACE_ALE_BIT] && PIN_OUT[`EXTERNAL_MEMORY_INTERFACE_P3] == s_q.addr[7:0] ##1 !PIN_OUT[`EXTERNAL_MEMORY_INTERFACE_ALE_BIT])
    else $error("Address latch phase wrong");
  a_nonmux_no_ale: assert property ((REQ.valid && REQ_READY && nonmux) |=> s_q.st != S_ALE)
    else $error("Address latch phase in separate mode");
  a_onchip_mode: assert property ((REQ.valid && REQ_READY && s_q.cfg[`EXTERNAL_MEMORY_INTERFACE_CFG_MODE] == `EXTERNAL_MEMORY_INTERFACE_MEM_ONCHIP) |=> RESP.done && RESP.onchip)
    else $error("On-chip-only mode went off chip");
  a_config_write: assert property ((apb_wr && PADDR == `EXTERNAL_MEMORY_INTERFACE_CFG_OFS) |=> s_q.cfg == $past(PWDATA[`EXTERNAL_MEMORY_INTERFACE_CFG_W-1:0]))
    else $error("Config register not updated");
  a_strobe_len: assert property (($rose(strobe) && s_q.tim[`EXTERNAL_MEMORY_INTERFACE_TIM_STRB] == 4'h3) |-> strobe[*3] ##1 !strobe)
    else $error("Strobe length differs from timing field");
  a_strobe_inactive: assert property ((claim && !strobe) |-> PIN_OUT[`EXTERNAL_MEMORY_INTERFACE_WR_BIT] && PIN_OUT[`EXTERNAL_MEMORY_INTERFACE_RD_BIT])
    else $error("Strobe low outside the strobe phase");

  c_offchip_read: cover property (strobe && !s_q.wr ##1 s_q.st == S_HOLD);
  c_offchip_write: cover property (strobe && s_q.wr);
  c_mux_access: cover property (s_q.st == S_ALE);
  c_onchip_done: cover property (RESP.done && RESP.onchip);
endmodule : ext_mem_pin_ctrl

// ### tb/ext_mem_model.sv
// Behavioural byte-wide external memory seen through the interface pins
`timescale 1ns/1ps
module ext_mem_model
(
  input wire logic clock,
  input wire logic [31:0] lvl,
  input wire logic nonmux,
  output logic [7:0] drv_val,
  output logic drv_en
);
  logic [7:0] mem [0:255];
  logic [7:0] alo_q;
  logic [7:0] lo;
  logic [7:0] dat;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5A;
  end
  assign lo = nonmux ? lvl[23:16] : alo_q;
  assign dat = nonmux ? lvl[31:24] : lvl[23:16];
  // Only the low address byte is decoded, so the bench shadow is 256 bytes
  always @(posedge clock)
  begin
    if (!nonmux && lvl[5])
      alo_q <= lvl[23:16];
    if (!lvl[7])
      mem[lo] <= dat;
  end
  // Drives only while the read strobe is low; the lane is free otherwise
  assign drv_en = !lvl[6];
  assign drv_val = mem[lo];
endmodule : ext_mem_model

// ### tb/tb_external_memory_pin_control.sv
// Self-checking bench for the external memory pin control block
`timescale 1ns/1ps
module tb_external_memory_pin_control;
  import external_memory_interface_pkg::*;
  logic CLOCK = 1'b0;
  logic RESET = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] XBAR_SEL = 32'h0000_0000;
  mem_req_t REQ = '0;
  pin_bus_t XBAR = '0;
  logic [31:0] PRDATA, PIN_IN, PIN_OUT, PIN_OE, md, rd;
  logic PREADY, PSLVERR, REQ_READY, de, err;
  mem_resp_t RESP;
  logic [31:0] seed = 32'h6597_1692;
  logic [31:0] pat = 32'hA5A5_A5A5;
  logic [31:0] pp = 32'h0000_0000;
  logic [31:0] latch = 32'hFFFF_FFFF;
  logic [7:0] dv;
  logic [7:0] shadow [0:255];
  logic [3:0] cfg = 4'h0;
  logic [11:0] tim = 12'h111;
  logic [15:0] a;
  logic [7:0] ra [0:6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [31:0] rv [0:6] = '{32'h0000_0000, 32'h0000_0111, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000};
  int mismatches = 0;
  int compares = 0;

  ext_mem_pin_ctrl ext_mem_pin_ctrl_i (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .REQ(REQ), .REQ_READY(REQ_READY), .RESP(RESP), .XBAR(XBAR), .XBAR_SEL(XBAR_SEL), .PIN_IN(PIN_IN),
    .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));
  ext_mem_model ext_mem_model_i (.clock(CLOCK), .lvl(PIN_IN), .nonmux(cfg[2]), .drv_val(dv), .drv_en(de));

  always #12.5 CLOCK = ~CLOCK;
  always @(posedge CLOCK)
    pat <= ~pat;
  assign md = de ? (cfg[2] ? 32'hFF00_0000 : 32'h00FF_0000) : 32'h0000_0000;
  // Released open-drain lines float high on the pull-up; others toggle so stale values never pass
  assign PIN_IN = (PIN_OE & PIN_OUT) | (~PIN_OE & ((md & {4{dv}}) | (~md & (~pp | pat))));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic int mx(input logic [3:0] f);
    return (f == 4'h0) ? 1 : int'(f);
  endfunction : mx

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic guard(input int n, input int lim);
    if (n >= lim)
    begin
      mismatches++;
      finish_test();
    end
  endtask : guard

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    @(posedge CLOCK);
    while (PREADY !== 1'b1 && n < 20)
    begin
      @(posedge CLOCK);
      n++;
    end
    guard(n, 20);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask : apb

  task automatic mem(input logic w, input logic [7:0] d);
    logic off;
    logic [31:0] eo;
    logic rdy;
    int n, rl, wl, lat;
    off = cfg[3] && (cfg[1:0] == 2'h3 || (cfg[1:0] != 2'h0 && a >= 16'h2000));
    lat = off ? (cfg[2] ? 0 : 1) + mx(tim[3:0]) + mx(tim[7:4]) + mx(tim[11:8]) + 1 : 1;
    n = 0;
    rl = 0;
    wl = 0;
    REQ <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    // Ready is looked at mid-cycle so the taking edge is known; the request then drops at once
    do
    begin
      @(negedge CLOCK);
      rdy = REQ_READY;
      @(posedge CLOCK);
      n++;
    end
    while (rdy !== 1'b1 && n < 20);
    guard(int'(rdy !== 1'b1), 1);
    REQ <= '0;
    n = 0;
    do
    begin
      @(negedge CLOCK);
      n++;
      rl += int'(!PIN_IN[6]);
      wl += int'(!PIN_IN[7]);
      if (!PIN_IN[6])
        chk("data lane oe", 32'h0000_0000, PIN_OE & (cfg[2] ? 32'hFF00_0000 : 32'h00FF_0000));
      chk("open drain high", 32'h0000_0000, PIN_OE & PIN_OUT & ~pp);
    end
    while (RESP.done !== 1'b1 && n < 100);
    guard(n, 100);
    eo = (XBAR_SEL & XBAR.val) | (~XBAR_SEL & latch);
    chk("latency", 32'(lat), 32'(n));
    chk("onchip", 32'(!off), 32'(RESP.onchip));
    chk("read strobe", (off && !w) ? 32'(mx(tim[7:4])) : 32'h0000_0000, 32'(rl));
    chk("write strobe", (off && w) ? 32'(mx(tim[7:4])) : 32'h0000_0000, 32'(wl));
    chk("pins out", eo, PIN_OUT);
    chk("pins oe", (~XBAR_SEL | XBAR.en) & (pp | ~eo), PIN_OE);
    if (off && !w)
      chk("read data", {24'h00_0000, shadow[a[7:0]]}, {24'h00_0000, RESP.rdata});
    if (off && w)
      shadow[a[7:0]] = d;
    @(posedge CLOCK);
  endtask : mem

  initial
  begin
    for (int i = 0; i < 256; i++)
      shadow[i] = 8'(i) ^ 8'h5A;
    repeat (12) @(posedge CLOCK);
    RESET <= 1'b0;
    @(posedge CLOCK);
    chk("oe after reset", 32'h0000_0000, PIN_OE);
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, ra[i], 32'h0000_0000);
      chk("reset value", rv[i], rd);
      chk("slave error", 32'(ra[i] == 8'h18), 32'(err));
    end
    // Table of mode and bus style, port enable cleared only for mode 3 with separate bus, with random timing, drive modes and parking
    for (int i = 0; i < 32; i++)
    begin
      seed = lfsr(seed);
      cfg = {1'(i % 8 != 7), 1'((i / 4) % 2), 2'(i % 4)};
      tim = seed[11:0];
      seed = lfsr(seed);
      pp = seed;
      latch = lfsr(seed) | 32'h0000_00E0;
      XBAR_SEL <= ~seed & ~32'h0000_00E0;
      XBAR <= {lfsr(pp), seed};
      apb(1'b1, 8'h00, {28'h000_0000, cfg});
      apb(1'b1, 8'h04, {20'h0_0000, tim});
      apb(1'b1, 8'h0C, latch);
      apb(1'b1, 8'h10, pp);
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("config", {28'h000_0000, cfg}, rd);
      a = (i % 3 == 0) ? 16'h1FFF : (i % 3 == 1) ? 16'h2000 : seed[15:0];
      mem(1'b1, seed[23:16]);
      mem(1'b0, 8'h00);
    end
    finish_test();
  end
endmodule : tb_external_memory_pin_control
